//--- verilog/lx_pkg.sv
// shared constants, types and register map for the line exposure sequencer
package lx_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] TICK_OFF = 8'h04;
  localparam logic [7:0] USEC_OFF = 8'h08;
  localparam logic [7:0] PERIOD_OFF = 8'h0C;
  localparam logic [7:0] LPF_OFF = 8'h10;
  localparam logic [7:0] CMD_OFF = 8'h14;
  localparam logic [7:0] STATUS_OFF = 8'h18;
  localparam logic [7:0] FRAMES_OFF = 8'h1C;
  // control field positions
  localparam int TRIG_SWITCH_BIT = 0;
  localparam int TIMED_BIT = 1;
  localparam int FALLING_BIT = 2;
  localparam int REPEAT_BIT = 3;
  localparam int RATE_EN_BIT = 4;
  // command and status field positions
  localparam int START_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int ACQ_BIT = 0;
  localparam int EXPOSING_BIT = 1;
  localparam int LINE_CNT_POS = 16;
  // field widths
  localparam int TICK_W = 17;
  localparam int RAW_W = 12;
  localparam int USEC_W = 21;
  localparam int PERIOD_W = 20;
  // exposure tick count limits and reset values
  localparam logic [RAW_W-1:0] RAW_MIN = 12'h001;
  localparam logic [RAW_W-1:0] RAW_MAX = 12'hFFF;
  localparam logic [TICK_W-1:0] TICK_RESET = 17'h00014;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 20'h00000;
  localparam logic [15:0] LPF_RESET = 16'h0001;
  // microsecond field counts in 10 ns units, ten per tick
  localparam logic [USEC_W-1:0] USEC_PER_TICK = 21'h0000A;
  localparam logic [USEC_W-1:0] USEC_HALF_TICK = 21'h00005;
  // timing
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 100;
  localparam int TICK_CYCLES = (TICK_NS / CLK_NS) < 1 ? 1 : (TICK_NS / CLK_NS);
  localparam int OVERHEAD_NS = 1000;
  localparam int OVERHEAD_TICKS = (OVERHEAD_NS + TICK_NS - 1) / TICK_NS;
  // packed control word
  typedef struct packed {
    logic rate_en;          // line rate setting in use
    logic repeated_frames;  // acquisition_behaviour: 1 repeated, 0 one frame
    logic falling;          // external edge selection
    logic timed;            // exposure_control_selection: timed
    logic trigger_switch;   // line start taken from outside
  } cfg_t;
  localparam cfg_t CFG_RESET = '{default: 1'b0};
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WAIT = 3'b010,
    S_EXPOSE = 3'b100
  } seq_state_t;
endpackage : lx_pkg

//--- verilog/exposure_tick_timer.sv
// 100 ns tick divider and exposure down-counter
module exposure_tick_timer import lx_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [TICK_W-1:0] ticks_in,
  output logic tick_out,
  output logic done_out
);
  logic [15:0] div_reg;     // cycles within one tick
  logic [TICK_W-1:0] cnt_reg; // exposure ticks left

  // divider restarts on load so the first tick is a whole one
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= 16'h0000;
      tick_out <= 1'b0;
    end else if (load_in || div_reg == 16'(TICK_CYCLES - 1)) begin
      div_reg <= 16'h0000;
      tick_out <= !load_in;
    end else begin
      div_reg <= div_reg + 16'h0001;
      tick_out <= 1'b0;
    end
  end

  // down-counter loaded with the effective tick count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
      done_out <= 1'b0;
    end else if (load_in) begin
      cnt_reg <= ticks_in;
      done_out <= 1'b0;
    end else if (tick_out && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - TICK_W'(1);
      done_out <= (cnt_reg == TICK_W'(1));
    end else begin
      done_out <= 1'b0;
    end
  end
endmodule : exposure_tick_timer

//--- verilog/line_exposure_and_free_run_sequencer.sv
// line exposure timing and free-run line/frame sequencer
// Function
// - exposure equals tick count times 100 ns
// - tick count accepts 1 through 4095
// - settings time exposure when internal or timed
// - exposure also writable in microseconds
// - microsecond value rounds to nearest 100 ns
// - tick count change updates microsecond value
// - external timed exposure starts on chosen edge
// - trigger switch off: all triggers internal
// - lines paced by rate setting or maximum
// - lines grouped into frames of set height
// - one frame per start command
// - repeated frames until stop command
// - stop mid-frame sends partial frame
module line_exposure_and_free_run_sequencer import lx_pkg::*; #(
  parameter int LINE_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic line_trigger_in,
  output logic exposure_out,
  output logic line_start_out,
  output logic frame_start_out,
  output logic frame_end_out,
  output logic partial_frame_out,
  output logic acquiring_out
);
  // line counter must fit the status field
  generate
    if (LINE_W < 1 || LINE_W > 16) begin : g_bad_width
      $error("LINE_W must be 1 to 16");
    end
  endgenerate

  logic rst_meta_reg;  // first reset stage
  logic rst_sync_reg;  // released reset used everywhere
  cfg_t cfg_reg;       // control word
  logic [TICK_W-1:0] ticks_reg;  // effective exposure tick count
  logic [PERIOD_W-1:0] period_reg;  // line_rate_setting as ticks per line
  logic [LINE_W-1:0] lpf_reg;    // lines per frame
  logic [31:0] frames_reg;       // completed frames
  seq_state_t state_reg;
  logic [LINE_W-1:0] line_cnt_reg;  // lines so far in this frame
  logic [PERIOD_W-1:0] since_reg;   // ticks since last line start
  logic stop_pend_reg;  // stop held until the open line ends
  logic trig_q_reg;     // previous external trigger level
  logic tick;
  logic exp_done;
  logic launch;
  logic [PERIOD_W-1:0] min_period;
  logic [PERIOD_W-1:0] target;
  logic start_cmd;
  logic stop_cmd;
  logic edge_seen;
  logic go;
  logic [USEC_W-1:0] usec_round;
  logic [TICK_W-1:0] usec_ticks;
  logic [LINE_W-1:0] line_cnt_inc;

  // two-stage reset release; only the second stage is used
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // command strobes
  assign start_cmd = wr_in && addr_in == CMD_OFF && wdata_in[START_BIT];
  assign stop_cmd = wr_in && addr_in == CMD_OFF && wdata_in[STOP_BIT];

  // microsecond write: nearest whole tick, never zero
  assign usec_round = wdata_in[USEC_W-1:0] + USEC_HALF_TICK;
  assign usec_ticks = TICK_W'(usec_round / USEC_PER_TICK);

  // control register
  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_in && addr_in == CTRL_OFF) begin
      cfg_reg.trigger_switch <= wdata_in[TRIG_SWITCH_BIT];
      cfg_reg.timed <= wdata_in[TIMED_BIT];
      cfg_reg.falling <= wdata_in[FALLING_BIT];
      cfg_reg.repeated_frames <= wdata_in[REPEAT_BIT];
      cfg_reg.rate_en <= wdata_in[RATE_EN_BIT];
    end
  end

  // one store for both exposure views keeps them consistent
  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ticks_reg <= TICK_RESET;
    end else if (wr_in && addr_in == TICK_OFF) begin
      // out-of-range raw values are clamped into 1..4095
      if (wdata_in[31:RAW_W] != '0) begin
        ticks_reg <= TICK_W'(RAW_MAX);
      end else if (wdata_in[RAW_W-1:0] < RAW_MIN) begin
        ticks_reg <= TICK_W'(RAW_MIN);
      end else begin
        ticks_reg <= TICK_W'(wdata_in[RAW_W-1:0]);
      end
    end else if (wr_in && addr_in == USEC_OFF) begin
      // a value below half a tick would give zero; hold it at one tick
      if (usec_ticks == '0) begin
        ticks_reg <= TICK_W'(RAW_MIN);
      end else begin
        ticks_reg <= usec_ticks;
      end
    end
  end

  // line period and frame height
  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      period_reg <= PERIOD_RESET;
      lpf_reg <= LINE_W'(LPF_RESET);
    end else if (wr_in && addr_in == PERIOD_OFF) begin
      period_reg <= wdata_in[PERIOD_W-1:0];
    end else if (wr_in && addr_in == LPF_OFF) begin
      // a height of zero is taken as one line
      lpf_reg <= (wdata_in[LINE_W-1:0] == '0) ? LINE_W'(1) : wdata_in[LINE_W-1:0];
    end
  end

  // read port: data stand in the cycle after the strobe only
  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        CTRL_OFF: begin
          rdata_out <= 32'(cfg_reg);
        end
        TICK_OFF: begin
          // raw view saturates when the microsecond view went beyond it
          rdata_out <= (ticks_reg > TICK_W'(RAW_MAX)) ? 32'(RAW_MAX) : 32'(ticks_reg);
        end
        USEC_OFF: begin
          rdata_out <= 32'(ticks_reg) * 32'(USEC_PER_TICK);
        end
        PERIOD_OFF: begin
          rdata_out <= 32'(period_reg);
        end
        LPF_OFF: begin
          rdata_out <= 32'(lpf_reg);
        end
        STATUS_OFF: begin
          rdata_out <= 32'(acquiring_out) << ACQ_BIT | 32'(exposure_out) << EXPOSING_BIT
                       | 32'(line_cnt_reg) << LINE_CNT_POS;
        end
        FRAMES_OFF: begin
          rdata_out <= frames_reg;
        end
        default: begin
          rdata_out <= 32'h00000000; // unmapped
        end
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

  // tick source and exposure down-counter
  exposure_tick_timer u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_reg),
    .load_in(launch),
    .ticks_in(ticks_reg),
    .tick_out(tick),
    .done_out(exp_done)
  );

  // shortest line: exposure plus readout overhead
  assign min_period = PERIOD_W'(ticks_reg) + PERIOD_W'(OVERHEAD_TICKS);
  // slower of setting and maximum rate; disabled setting means maximum
  assign target = (cfg_reg.rate_en && period_reg > min_period) ? period_reg : min_period;

  // external edge detection
  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      trig_q_reg <= 1'b0;
    end else begin
      trig_q_reg <= line_trigger_in;
    end
  end
  assign edge_seen = cfg_reg.falling ? (trig_q_reg && !line_trigger_in) : (!trig_q_reg && line_trigger_in);
  // width-controlled external exposure is not served: such edges are ignored
  assign go = !cfg_reg.trigger_switch || (cfg_reg.timed && edge_seen);
  assign launch = state_reg == S_WAIT && !stop_cmd && !stop_pend_reg && since_reg >= target && go;
  assign line_cnt_inc = line_cnt_reg + LINE_W'(1);

  // ticks since last line start, saturating
  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      since_reg <= '1;
    end else if (launch) begin
      // launch edge and the tick lost to the timer reload both count for this line
      since_reg <= PERIOD_W'(2);
    end else if (state_reg == S_IDLE) begin
      since_reg <= '1; // first line leaves at once
    end else if (tick && since_reg != '1) begin
      since_reg <= since_reg + PERIOD_W'(1);
    end
  end

  // stop request waits for the line in exposure; in idle the clear beats a new stop
  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      stop_pend_reg <= 1'b0;
    end else if (stop_cmd && state_reg != S_IDLE) begin
      stop_pend_reg <= 1'b1;
    end else if (state_reg == S_IDLE) begin
      stop_pend_reg <= 1'b0;
    end
  end

  // acquisition sequencer
  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= S_IDLE;
      line_cnt_reg <= '0;
      frames_reg <= 32'h00000000;
      exposure_out <= 1'b0;
      line_start_out <= 1'b0;
      frame_start_out <= 1'b0;
      frame_end_out <= 1'b0;
      partial_frame_out <= 1'b0;
      acquiring_out <= 1'b0;
    end else begin
      line_start_out <= 1'b0;
      frame_start_out <= 1'b0;
      frame_end_out <= 1'b0;
      partial_frame_out <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          // acquisition start is internal; the command arms it
          if (start_cmd && !stop_cmd) begin
            state_reg <= S_WAIT;
            line_cnt_reg <= '0;
            acquiring_out <= 1'b1;
          end
        end
        S_WAIT: begin
          if (stop_cmd || stop_pend_reg) begin
            // flush what the frame holds
            if (line_cnt_reg != '0) begin
              frame_end_out <= 1'b1;
              partial_frame_out <= 1'b1;
              frames_reg <= frames_reg + 32'h00000001;
            end
            line_cnt_reg <= '0;
            state_reg <= S_IDLE;
            acquiring_out <= 1'b0;
          end else if (launch) begin
            exposure_out <= 1'b1;
            line_start_out <= 1'b1;
            frame_start_out <= (line_cnt_reg == '0);
            state_reg <= S_EXPOSE;
          end
        end
        S_EXPOSE: begin
          if (exp_done) begin
            exposure_out <= 1'b0;
            if (line_cnt_inc == lpf_reg) begin
              // frame complete
              frame_end_out <= 1'b1;
              frames_reg <= frames_reg + 32'h00000001;
              line_cnt_reg <= '0;
              if (!cfg_reg.repeated_frames || stop_cmd || stop_pend_reg) begin
                state_reg <= S_IDLE;
                acquiring_out <= 1'b0;
              end else begin
                state_reg <= S_WAIT;
              end
            end else begin
              line_cnt_reg <= line_cnt_inc;
              state_reg <= S_WAIT;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
          exposure_out <= 1'b0;
          acquiring_out <= 1'b0;
        end
      endcase
    end
  end
endmodule : line_exposure_and_free_run_sequencer

//--- bench/lx_properties.sv
// port-level checks for the line exposure sequencer
module lx_properties import lx_pkg::*; #(
  parameter int LINE_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic line_trigger_in,
  input wire logic exposure_out,
  input wire logic line_start_out,
  input wire logic frame_start_out,
  input wire logic frame_end_out,
  input wire logic partial_frame_out,
  input wire logic acquiring_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain, so one clock and one reset for all
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // read data shows only in the slot after a read
  rdata_quiet_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside its slot");
  // an in-range tick count reads back unchanged
  tick_readback_a: assert property ((wr_in && addr_in == TICK_OFF && wdata_in >= 32'h1 && wdata_in <= 32'hFFF)
    ##1 !wr_in ##1 (rd_in && addr_in == TICK_OFF) |=> rdata_out == $past(wdata_in, 3)) else $error("tick readback");
  // microsecond value snaps to the nearest tick
  usec_round_a: assert property ((wr_in && addr_in == USEC_OFF && wdata_in >= 32'h5 && wdata_in <= 32'h9FF6)
    ##1 !wr_in ##1 (rd_in && addr_in == USEC_OFF) |=> rdata_out == (($past(wdata_in, 3) + 32'h5) / 32'hA) * 32'hA)
    else $error("microsecond rounding");
  frame_head_a: assert property (frame_start_out |-> line_start_out)
    else $error("frame start without line start");
  partial_end_a: assert property (partial_frame_out |-> frame_end_out)
    else $error("partial flag without frame end");
  line_expose_a: assert property (line_start_out |-> exposure_out)
    else $error("line start without exposure");
  line_pulse_a: assert property (line_start_out |=> !line_start_out)
    else $error("line start longer than one cycle");
  line_acq_a: assert property (line_start_out |-> acquiring_out)
    else $error("line outside acquisition");
  frame_close_a: assert property (frame_end_out |-> !exposure_out)
    else $error("frame closed while exposing");
  cover property (line_start_out ##[1:60] partial_frame_out);
  cover property (frame_end_out && !partial_frame_out);
  cover property ($fell(acquiring_out));
endmodule : lx_properties

//--- bench/testbench.sv
// self-checking bench for the line exposure sequencer
module testbench import lx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_n_in, wr_in, rd_in, line_trigger_in;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, f;
  logic exposure_out, line_start_out, frame_start_out, frame_end_out, partial_frame_out, acquiring_out;
  int miscompares, num_checks, cycles, lines, fstarts, fends, parts, gap, elen, t0;
  line_exposure_and_free_run_sequencer #(.LINE_W(16)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .line_trigger_in(line_trigger_in), .exposure_out(exposure_out), .line_start_out(line_start_out),
    .frame_start_out(frame_start_out), .frame_end_out(frame_end_out),
    .partial_frame_out(partial_frame_out), .acquiring_out(acquiring_out));
  // 100 ns clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // hang guard, well above the roughly 500 cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // one-cycle write strobe, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // data is taken in the cycle after the strobe, its only slot
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask : rdchk
  // counts pulses over n cycles and the spacing of the first two lines
  task automatic watch(input int n);
    lines = 0; fstarts = 0; fends = 0; parts = 0; gap = 0; elen = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      #1;
      if (line_start_out === 1'b1) begin
        if (lines == 1) gap = i - t0;
        t0 = i;
        lines++;
      end
      fstarts += int'(frame_start_out === 1'b1);
      fends += int'(frame_end_out === 1'b1);
      parts += int'(partial_frame_out === 1'b1);
      elen += int'(exposure_out === 1'b1);
    end
  endtask : watch
  task automatic t_regs();
    rdchk("ctrl", CTRL_OFF, 32'h0);
    rdchk("tick", TICK_OFF, 32'h14);
    rdchk("usec", USEC_OFF, 32'hC8);
    rdchk("lpf", LPF_OFF, 32'h1);
    rdchk("unmapped", 8'h20, 32'h0);
    wr(TICK_OFF, 32'h0);
    rdchk("tick low clamp", TICK_OFF, 32'h1);
    wr(TICK_OFF, 32'h1388);
    rdchk("tick high clamp", TICK_OFF, 32'hFFF);
    wr(TICK_OFF, 32'h7);
    rdchk("tick", TICK_OFF, 32'h7);
    rdchk("usec follows tick", USEC_OFF, 32'h46);
    wr(USEC_OFF, 32'hD4);
    rdchk("usec round down", USEC_OFF, 32'hD2);
    rdchk("tick from usec", TICK_OFF, 32'h15);
    wr(USEC_OFF, 32'hD7);
    rdchk("usec round up", USEC_OFF, 32'hDC);
    wr(USEC_OFF, 32'h4);
    rdchk("usec floor tick", TICK_OFF, 32'h1);
  endtask : t_regs
  // one frame of two lines at the fastest rate, 20 ticks each
  task automatic t_single();
    wr(CTRL_OFF, 32'h0);
    wr(TICK_OFF, 32'h14);
    wr(LPF_OFF, 32'h2);
    rd(FRAMES_OFF, f);
    wr(CMD_OFF, 32'h1);
    watch(60);
    chk("lines", lines, 2);
    chk("frame starts", fstarts, 1);
    chk("frame ends", fends, 1);
    chk("partials", parts, 0);
    chk("max rate spacing", gap, 20 + OVERHEAD_TICKS);
    chk("exposure cycles", elen >= 40 && elen <= 44, 1);
    chk("acquiring", acquiring_out, 1'b0);
    rdchk("frames", FRAMES_OFF, f + 32'h1);
  endtask : t_single
  // repeated frames of three at a 40 tick period, stopped mid-frame
  task automatic t_repeat();
    wr(CTRL_OFF, 32'h18);
    wr(TICK_OFF, 32'h14);
    wr(PERIOD_OFF, 32'h28);
    wr(LPF_OFF, 32'h3);
    wr(CMD_OFF, 32'h1);
    watch(150);
    chk("lines", lines, 4);
    chk("frame starts", fstarts, 2);
    chk("frame ends", fends, 1);
    chk("set rate spacing", gap, 40);
    // one line of the second frame is in, waiting for the next slot
    rdchk("status mid-frame", STATUS_OFF, 32'h00010001);
    wr(CMD_OFF, 32'h2);
    // the flush pulses stand only in the cycle after the stop strobe
    #1;
    chk("partial end", frame_end_out, 1'b1);
    chk("partial flag", partial_frame_out, 1'b1);
    watch(20);
    chk("lines after stop", lines, 0);
    chk("acquiring", acquiring_out, 1'b0);
  endtask : t_repeat
  // external line start: rising, falling, then timed control off
  task automatic t_ext();
    wr(LPF_OFF, 32'h1);
    for (int e = 0; e < 3; e++) begin
      wr(CTRL_OFF, (e == 2) ? 32'h1 : (32'h3 | (e << 2)));
      @(posedge clk_in);
      line_trigger_in <= (e == 1);
      wr(CMD_OFF, 32'h1);
      watch(30);
      chk("lines before edge", lines, 0);
      @(posedge clk_in);
      line_trigger_in <= (e != 1);
      watch(30);
      chk("lines after edge", lines, (e == 2) ? 0 : 1);
      wr(CMD_OFF, 32'h2);
    end
  endtask : t_ext
  initial begin
    rst_n_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    line_trigger_in = 1'b0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_single();
    t_repeat();
    t_ext();
    close_out();
  end
endmodule : testbench
bind line_exposure_and_free_run_sequencer lx_properties #(.LINE_W(LINE_W)) props (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .line_trigger_in(line_trigger_in), .exposure_out(exposure_out),
  .line_start_out(line_start_out), .frame_start_out(frame_start_out), .frame_end_out(frame_end_out),
  .partial_frame_out(partial_frame_out), .acquiring_out(acquiring_out));
